// file: rtl/capture_regs.svh
// Register indices, field positions and codes of the capture channels
`ifndef CAPTURE_REGS_SVH
`define CAPTURE_REGS_SVH
`define IC_BUF_IDX1   10'h140
`define IC_CON_IDX1   10'h142
`define IC_BUF_IDX2   10'h144
`define IC_CON_IDX2   10'h146
`define IC_BUF_IDX7   10'h158
`define IC_CON_IDX7   10'h15a
`define IC_BUF_IDX8   10'h15c
`define IC_CON_IDX8   10'h15e
`define IC_FLAG_IDX   10'h160
`define IC_EN_IDX     10'h161
`define CON_MODE_LO   0
`define CON_BNE       3
`define CON_OV        4
`define CON_ICI_LO    5
`define CON_TSEL      7
`define CON_SIDL      13
`define MODE_OFF      3'h0
`define MODE_BOTH     3'h1
`define MODE_FALL     3'h2
`define MODE_RISE     3'h3
`define MODE_RISE4    3'h4
`define MODE_RISE16   3'h5
`define MODE_INT      3'h7
`define PS4_LAST      4'h3
`define PS16_LAST     4'hf
`define FIFO_DEPTH    3'h4
`define FIFO_LAST     2'h3
`endif

// file: rtl/capture_pkg.sv
// Types shared by the capture channel design
package capture_pkg;
  typedef struct packed {
    logic       stop_in_idle;
    logic       time_base_select;
    logic [1:0] interrupt_count_field;
    logic [2:0] capture_mode_field;
  } ctrl_t;
  typedef struct packed {
    logic        running;
    logic [15:0] count;
  } timer_t;
endpackage

// file: rtl/input_capture_channel.sv
// Four input capture channels with APB register access
`timescale 1ns/100ps
`default_nettype none
`include "capture_regs.svh"
module input_capture_channel (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [3:0]        capture_pin,
  input  wire capture_pkg::timer_t timer2,
  input  wire capture_pkg::timer_t timer3,
  input  wire logic              cpu_sleep,
  input  wire logic              cpu_idle,
  output var  logic [3:0]        channel_interrupt_flag,
  output var  logic              wake_request
);
  import capture_pkg::*;

  // Pin order: one, two, seven, eight
  localparam logic [9:0] BUF_IDX [4] = '{`IC_BUF_IDX1, `IC_BUF_IDX2,
                                         `IC_BUF_IDX7, `IC_BUF_IDX8};
  localparam logic [9:0] CON_IDX [4] = '{`IC_CON_IDX1, `IC_CON_IDX2,
                                         `IC_CON_IDX7, `IC_CON_IDX8};

  function automatic logic [15:0] con_word(ctrl_t c, logic bne, logic ov);
    logic [15:0] w;
    w = 16'h0000;
    w[`CON_MODE_LO +: 3] = c.capture_mode_field;
    w[`CON_BNE] = bne;
    w[`CON_OV] = ov;
    w[`CON_ICI_LO +: 2] = c.interrupt_count_field;
    w[`CON_TSEL] = c.time_base_select;
    w[`CON_SIDL] = c.stop_in_idle;
    return w;
  endfunction

  ctrl_t       ctrl [4];
  logic [15:0] mem [4][4];
  logic [2:0]  cnt [4];
  logic        ov [4];
  logic [3:0]  ps [4];
  logic [1:0]  icnt [4];
  logic [2:0]  sync [4];
  logic        lvl [4];
  logic [3:0]  int_enable;

  ctrl_t       next_ctrl [4];
  logic [2:0]  next_cnt [4];
  logic        next_ov [4];
  logic [3:0]  next_ps [4];
  logic [1:0]  next_icnt [4];
  logic [3:0]  next_flag;
  logic [31:0] next_prdata;

  // Bus decode
  wire        access = psel & penable;
  wire        done   = access & pready;
  wire [9:0]  idx    = paddr[11:2];
  wire        aligned = (paddr[1:0] == 2'h0);
  wire        flag_hit = aligned & (idx == `IC_FLAG_IDX);
  wire        en_hit   = aligned & (idx == `IC_EN_IDX);
  wire [3:0]  buf_hit;
  wire [3:0]  con_hit;
  wire        any_hit = flag_hit | en_hit | (|buf_hit) | (|con_hit);
  wire        wr_done = done & pwrite & ~pslverr;
  wire        rd_done = done & ~pwrite & ~pslverr;

  // Per-channel event wires
  wire [3:0]  rise;
  wire [3:0]  fall;
  wire [3:0]  edge_evt;
  wire [3:0]  store;
  wire [3:0]  pop;
  wire [3:0]  accept;
  wire [3:0]  ovf_evt;
  wire [3:0]  irq_evt;
  wire [3:0]  wake_evt;
  wire [3:0]  bne;
  wire [15:0] ts [4];
  wire [1:0]  wpos [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ch
      wire [2:0] m       = ctrl[g].capture_mode_field;
      wire       settled = (sync[g][1] == sync[g][2]) & (sync[g][2] != lvl[g]);
      wire       full    = (cnt[g] == `FIFO_DEPTH);
      wire       tmr_on  = ctrl[g].time_base_select ? timer2.running : timer3.running;
      wire       idle_stop = cpu_idle & (ctrl[g].stop_in_idle | ~tmr_on);
      wire       int_only  = (m == `MODE_INT) & (cpu_sleep | cpu_idle);
      assign buf_hit[g] = aligned & (idx == BUF_IDX[g]);
      assign con_hit[g] = aligned & (idx == CON_IDX[g]);
      assign rise[g] = settled & sync[g][2];
      assign fall[g] = settled & ~sync[g][2];
      assign ts[g] = ctrl[g].time_base_select ? timer2.count : timer3.count;
      // Qualifying edge per mode
      assign edge_evt[g] =
        cpu_sleep ? ((m == `MODE_INT) & rise[g]) :
        (m == `MODE_BOTH)   ? (rise[g] | fall[g]) :
        (m == `MODE_FALL)   ? fall[g] :
        (m == `MODE_RISE)   ? rise[g] :
        (m == `MODE_INT)    ? rise[g] :
        (m == `MODE_RISE4)  ? (rise[g] & (ps[g] == `PS4_LAST)) :
        (m == `MODE_RISE16) ? (rise[g] & (ps[g] == `PS16_LAST)) : 1'b0;
      assign store[g] = edge_evt[g] & ~int_only & ~idle_stop & ~cpu_sleep;
      assign pop[g] = rd_done & buf_hit[g] & (cnt[g] != 3'h0);
      assign accept[g] = store[g] & ~ov[g] & (~full | pop[g]);
      assign ovf_evt[g] = store[g] & full & ~pop[g] & ~ov[g] &
                          (m != `MODE_BOTH);
      assign wpos[g] = pop[g] ? 2'(cnt[g] - 3'h1) : cnt[g][1:0];
      assign bne[g] = (cnt[g] != 3'h0);
      // Interrupt: sleep or idle-interrupt-only and both-edges flag on each event
      assign irq_evt[g] = (int_only | cpu_sleep) ? edge_evt[g] :
                          (m == `MODE_BOTH) ? store[g] :
                          (store[g] & (icnt[g] == ctrl[g].interrupt_count_field));
      assign wake_evt[g] = edge_evt[g] & (m == `MODE_INT) & int_enable[g] &
                           (cpu_sleep | cpu_idle);
    end
  endgenerate

  // Next state of channel state
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_ctrl[i] = ctrl[i];
      if (wr_done && con_hit[i]) begin
        next_ctrl[i].capture_mode_field    = pwdata[`CON_MODE_LO +: 3];
        next_ctrl[i].interrupt_count_field = pwdata[`CON_ICI_LO +: 2];
        next_ctrl[i].time_base_select      = pwdata[`CON_TSEL];
        next_ctrl[i].stop_in_idle          = pwdata[`CON_SIDL];
      end
      next_cnt[i] = cnt[i];
      if (accept[i] && !pop[i]) begin
        next_cnt[i] = cnt[i] + 3'h1;
      end else if (pop[i] && !accept[i]) begin
        next_cnt[i] = cnt[i] - 3'h1;
      end
      // Overflow holds until the buffer is drained
      next_ov[i] = ovf_evt[i] | (ov[i] & (next_cnt[i] != 3'h0));
      next_ps[i] = ps[i];
      if (ctrl[i].capture_mode_field == `MODE_OFF) begin
        next_ps[i] = 4'h0;
      end else if (rise[i] && !cpu_sleep &&
                   (ctrl[i].capture_mode_field == `MODE_RISE4 ||
                    ctrl[i].capture_mode_field == `MODE_RISE16)) begin
        if ((ctrl[i].capture_mode_field == `MODE_RISE4 && ps[i] == `PS4_LAST) ||
            ps[i] == `PS16_LAST) begin
          next_ps[i] = 4'h0;
        end else begin
          next_ps[i] = ps[i] + 4'h1;
        end
      end
      next_icnt[i] = icnt[i];
      if (ctrl[i].capture_mode_field == `MODE_OFF) begin
        next_icnt[i] = 2'h0;
      end else if (store[i] && ctrl[i].capture_mode_field != `MODE_BOTH) begin
        next_icnt[i] = irq_evt[i] ? 2'h0 : icnt[i] + 2'h1;
      end
    end
  end

  // Hardware set wins over a software write-one clear
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_flag[i] = irq_evt[i] |
                     (channel_interrupt_flag[i] & ~(wr_done & flag_hit & pwdata[i]));
    end
  end

  // Read data
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (flag_hit) begin
      next_prdata[3:0] = channel_interrupt_flag;
    end else if (en_hit) begin
      next_prdata[3:0] = int_enable;
    end
    for (int i = 0; i < 4; i++) begin
      if (buf_hit[i]) begin
        next_prdata[15:0] = mem[i][0];
      end
      if (con_hit[i]) begin
        next_prdata[15:0] = con_word(ctrl[i], bne[i], ov[i]);
      end
    end
  end

  // Bus slave: one wait cycle, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~any_hit;
      if (access && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  // Control, status and input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        ctrl[i] <= '0;
        cnt[i]  <= 3'h0;
        ov[i]   <= 1'b0;
        ps[i]   <= 4'h0;
        icnt[i] <= 2'h0;
        sync[i] <= 3'h0;
        lvl[i]  <= 1'b0;
      end
      int_enable             <= 4'h0;
      channel_interrupt_flag <= 4'h0;
      wake_request           <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        ctrl[i] <= next_ctrl[i];
        cnt[i]  <= next_cnt[i];
        ov[i]   <= next_ov[i];
        ps[i]   <= next_ps[i];
        icnt[i] <= next_icnt[i];
        sync[i] <= {sync[i][1:0], capture_pin[i]};
        if (sync[i][1] == sync[i][2]) begin
          lvl[i] <= sync[i][2];
        end
      end
      if (wr_done && en_hit) begin
        int_enable <= pwdata[3:0];
      end
      channel_interrupt_flag <= next_flag;
      wake_request           <= |wake_evt;
    end
  end

  // Capture buffer storage
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        if (pop[i] && k < 3) begin
          mem[i][k] <= mem[i][k+1];
        end
        if (accept[i] && wpos[i] == 2'(k)) begin
          mem[i][k] <= ts[i];
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  generate
    for (g = 0; g < 4; g++) begin : gen_chk
      a_bne_tracks_cnt: assert property (
        accept[g] |=> bne[g])
        else $error("not-empty flag low after a capture");
      a_cnt_bounded: assert property (
        cnt[g] <= `FIFO_DEPTH)
        else $error("buffer count above depth");
      a_ov_on_fifth: assert property (
        (store[g] && cnt[g] == `FIFO_DEPTH && !pop[g] && !ov[g] &&
         ctrl[g].capture_mode_field != `MODE_BOTH) |=> (ov[g] && cnt[g] == `FIFO_DEPTH))
        else $error("fifth capture did not raise overflow");
      a_ov_blocks_store: assert property (
        (ov[g] && !pop[g]) |=> ($stable(cnt[g]) || cnt[g] == 3'h0))
        else $error("capture stored while overflowed");
      a_both_no_ov: assert property (
        (ctrl[g].capture_mode_field == `MODE_BOTH && !ov[g]) |=> !ov[g] ||
        $past(ctrl[g].capture_mode_field) != `MODE_BOTH)
        else $error("overflow raised in both-edges mode");
      a_pop_shifts: assert property (
        (pop[g] && !accept[g] && cnt[g] > 3'h1) |=> (mem[g][0] == $past(mem[g][1])))
        else $error("read did not advance the buffer");
      a_off_clears_ps: assert property (
        (ctrl[g].capture_mode_field == `MODE_OFF) |=> (ps[g] == 4'h0))
        else $error("prescaler not cleared while off");
      a_sleep_no_store: assert property (
        cpu_sleep |=> ($past(cnt[g]) >= cnt[g]))
        else $error("capture stored during sleep");
      a_both_flag_each: assert property (
        (store[g] && ctrl[g].capture_mode_field == `MODE_BOTH && !cpu_idle)
        |=> channel_interrupt_flag[g])
        else $error("both-edges capture did not set the flag");
      a_wake_mode111: assert property (
        (rise[g] && ctrl[g].capture_mode_field == `MODE_INT && int_enable[g] &&
         cpu_sleep) |=> (wake_request && channel_interrupt_flag[g]))
        else $error("no wake on mode 111 edge in sleep");
      a_bne_holds: assert property (
        (bne[g] && !pop[g])
        |=> bne[g])
        else $error("not-empty flag fell without a read");
      a_pop_count: assert property (
        (pop[g] && !accept[g])
        |=> (cnt[g] == $past(cnt[g]) - 3'h1))
        else $error("read did not lower the buffer count");
      a_ov_keeps_value: assert property (
        ovf_evt[g]
        |=> (mem[g][3] == $past(mem[g][3])))
        else $error("fifth capture overwrote the buffer");
      a_ov_clears_empty: assert property (
        (ov[g] && cnt[g] == 3'h1 && pop[g] && !accept[g])
        |=> !ov[g])
        else $error("overflow stayed after the buffer drained");
      a_fall_edges: assert property (
        (store[g] && ctrl[g].capture_mode_field == `MODE_FALL)
        |-> fall[g])
        else $error("falling-edge mode stored on another edge");
      a_rise_edges: assert property (
        (store[g] && ctrl[g].capture_mode_field == `MODE_RISE)
        |-> rise[g])
        else $error("rising-edge mode stored on another edge");
      a_rise4_prescale: assert property (
        (store[g] && ctrl[g].capture_mode_field == `MODE_RISE4)
        |-> (rise[g] && ps[g] == `PS4_LAST))
        else $error("every-4th mode stored off its count");
      a_time_base: assert property (
        (accept[g] && !pop[g] && cnt[g] == 3'h0)
        |=> (mem[g][0] == ($past(ctrl[g].time_base_select) ?
                           $past(timer2.count) : $past(timer3.count))))
        else $error("capture took the wrong time base");
      a_both_irq_each: assert property (
        (store[g] && ctrl[g].capture_mode_field == `MODE_BOTH)
        |-> irq_evt[g])
        else $error("both-edges capture without interrupt");
      a_sleep_irq_rise: assert property (
        (cpu_sleep && irq_evt[g])
        |-> (ctrl[g].capture_mode_field == `MODE_INT && rise[g]))
        else $error("sleep interrupt from a wrong mode or edge");
      a_idle_stop: assert property (
        (cpu_idle && ctrl[g].stop_in_idle)
        |-> !accept[g])
        else $error("capture stored while stopped in idle");
      a_idle_int_only: assert property (
        (cpu_idle && ctrl[g].capture_mode_field == `MODE_INT)
        |-> !accept[g])
        else $error("interrupt-only mode stored in idle");
      a_ici_flag: assert property (
        (store[g] && ctrl[g].capture_mode_field != `MODE_BOTH &&
         icnt[g] == ctrl[g].interrupt_count_field)
        |=> (channel_interrupt_flag[g] && icnt[g] == 2'h0))
        else $error("interrupt count reached without flag");
      a_flag_set_wins: assert property (
        irq_evt[g]
        |=> channel_interrupt_flag[g])
        else $error("interrupt event lost against a clear");
      a_off_no_store: assert property (
        (ctrl[g].capture_mode_field == `MODE_OFF)
        |-> !store[g])
        else $error("capture stored while channel off");
    end
  endgenerate

  // Bus answer and wake pulse shape
  a_ready_pulse: assert property (
    pready
    |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (
    pslverr
    |-> pready)
    else $error("error response without ready");
  a_wake_low_power: assert property (
    wake_request
    |-> ($past(cpu_sleep) || $past(cpu_idle)))
    else $error("wake pulse outside sleep or idle");

endmodule // input_capture_channel
`default_nettype wire

// file: testbench/capture_pin_model.sv
// Model of the external signals driven onto the capture input pins
`timescale 1ns/100ps
`default_nettype none
module capture_pin_model (
  input  wire logic       pclk,
  output var  logic [3:0] pins
);
  initial pins = 4'h0;
  // One edge on one pin, then the level is held so it qualifies
  task automatic drive(input int ch, input logic lvl);
    @(posedge pclk);
    pins[ch] <= lvl;
    repeat (8) @(posedge pclk);
  endtask
endmodule // capture_pin_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the input capture channels
`timescale 1ns/100ps
`default_nettype none
`include "capture_regs.svh"
module tb;
  import capture_pkg::*;
  localparam logic [11:0] fa = {`IC_FLAG_IDX, 2'b00};
  localparam logic [11:0] ea = {`IC_EN_IDX, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cpu_sleep, cpu_idle, wake_request, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pins, flags;
  timer_t      timer2, timer3;
  logic [15:0] fifo_q[$];
  logic [9:0]  con_idx[4] = '{`IC_CON_IDX1, `IC_CON_IDX2, `IC_CON_IDX7, `IC_CON_IDX8};
  logic [9:0]  buf_idx[4] = '{`IC_BUF_IDX1, `IC_BUF_IDX2, `IC_BUF_IDX7, `IC_BUF_IDX8};
  logic [2:0]  modes[4] = '{`MODE_FALL, `MODE_RISE, `MODE_RISE4, `MODE_RISE16};
  int          mismatches = 0;
  int          n_tests = 0;
  int          wakes = 0;
  input_capture_channel u_input_capture_channel (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(pins), .timer2(timer2), .timer3(timer3), .cpu_sleep(cpu_sleep),
    .cpu_idle(cpu_idle), .channel_interrupt_flag(flags), .wake_request(wake_request)
  );
  capture_pin_model u_capture_pin_model (.pclk(pclk), .pins(pins));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (wake_request === 1'b1) begin
      wakes <= wakes + 1;
    end
  end
  task automatic complete_run();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (i >= 40) begin
      mismatches++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] adr(input int c, input logic con);
    return {con ? con_idx[c] : buf_idx[c], 2'b00};
  endfunction
  function automatic int exp_caps(input logic [2:0] md, input int p);
    return md == `MODE_RISE4 ? p / 4 : (md == `MODE_RISE16 ? p / 16 : p);
  endfunction
  task automatic cfg(input int c, input logic [2:0] md, input logic [1:0] ici, input logic t);
    apb(1'b1, adr(c, 1'b1), {24'h0, t, ici, 2'b00, md});
  endtask
  // Edge with fresh, held timer counts
  task automatic ev(input int c, input logic lvl);
    @(posedge pclk);
    timer2.count <= 16'($urandom);
    timer3.count <= 16'($urandom);
    u_capture_pin_model.drive(c, lvl);
  endtask
  // Reads only while not empty; checks values in order
  task automatic drain(input int c, output int n);
    n = 0;
    apb(1'b0, adr(c, 1'b1), 32'h0);
    while (q[`CON_BNE] === 1'b1 && n < 8) begin
      apb(1'b0, adr(c, 1'b0), 32'h0);
      if (fifo_q.size() > 0) begin
        chk("capture value", {16'h0, fifo_q.pop_front()}, q);
      end
      n++;
      apb(1'b0, adr(c, 1'b1), 32'h0);
    end
  endtask
  initial begin
    int ch, n, k, m, p, w;
    logic t;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    timer2 = '{1'b1, 16'h0};
    timer3 = '{1'b1, 16'h0};
    {cpu_sleep, cpu_idle, presetn} = '0;
    k = $urandom(11969);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    ch = $urandom % 4;
    t = 1'($urandom);
    apb(1'b0, adr(ch, 1'b1), 32'h0);
    chk("control reset", 32'h0, q);
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped error", 32'h1, 32'(e));
    cfg(ch, `MODE_RISE, 2'h0, t);
    for (k = 0; k < 5; k++) begin
      ev(ch, 1'b1);
      if (k < 4) begin
        fifo_q.push_back(t ? timer2.count : timer3.count);
      end
      ev(ch, 1'b0);
      apb(1'b0, adr(ch, 1'b1), 32'h0);
      chk("not empty", 32'h1, 32'(q[`CON_BNE]));
      chk("overflow", 32'(k == 4), 32'(q[`CON_OV]));
    end
    apb(1'b0, adr(ch, 1'b0), 32'h0);
    chk("oldest", {16'h0, fifo_q.pop_front()}, q);
    ev(ch, 1'b1);
    ev(ch, 1'b0);
    drain(ch, n);
    chk("held after overflow", 32'h3, 32'(n));
    cfg(ch, `MODE_BOTH, 2'h3, 1'b0);
    for (k = 0; k < 6; k++) begin
      apb(1'b1, fa, 32'hf);
      ev(ch, ~k[0]);
      if (k < 4) begin
        fifo_q.push_back(timer3.count);
      end
      chk("edge flag", 32'h1, 32'(flags[ch]));
    end
    apb(1'b0, adr(ch, 1'b1), 32'h0);
    chk("both no overflow", 32'h0, 32'(q[`CON_OV]));
    drain(ch, n);
    chk("both keeps four", 32'h4, 32'(n));
    for (m = 0; m < 4; m++) begin
      p = m < 2 ? 1 + $urandom % 4 : (m == 2 ? 4 + $urandom % 12 : 16 + $urandom % 8);
      cfg(ch, modes[m], 2'h0, 1'b1);
      for (k = 0; k < p; k++) begin
        ev(ch, 1'b1);
        ev(ch, 1'b0);
      end
      drain(ch, n);
      chk("mode captures", 32'(exp_caps(modes[m], p)), 32'(n));
      cfg(ch, `MODE_OFF, 2'h0, 1'b0);
    end
    cfg(ch, `MODE_RISE4, 2'h0, 1'b0);
    for (k = 0; k < 5; k++) begin
      if (k == 2) begin
        cfg(ch, `MODE_OFF, 2'h0, 1'b0);
        cfg(ch, `MODE_RISE4, 2'h0, 1'b0);
      end
      ev(ch, 1'b1);
      ev(ch, 1'b0);
    end
    drain(ch, n);
    chk("prescale cleared", 32'h0, 32'(n));
    p = $urandom % 4;
    cfg(ch, `MODE_RISE, 2'(p), 1'b0);
    apb(1'b1, fa, 32'hf);
    for (k = 0; k <= p; k++) begin
      ev(ch, 1'b1);
      fifo_q.push_back(timer3.count);
      chk("count flag", 32'(k == p), 32'(flags[ch]));
      ev(ch, 1'b0);
    end
    drain(ch, n);
    chk("count captures", 32'(p + 1), 32'(n));
    apb(1'b1, ea, 32'h1 << ch);
    apb(1'b0, ea, 32'h0);
    chk("enable readback", 32'h1 << ch, q);
    timer2.running <= 1'b0;
    timer3.running <= 1'b0;
    for (k = 0; k < 2; k++) begin
      cpu_sleep <= (k == 0);
      cpu_idle <= (k == 1);
      cfg(ch, `MODE_INT, k == 0 ? 2'h3 : 2'h0, 1'b0);
      apb(1'b1, fa, 32'hf);
      w = wakes;
      ev(ch, 1'b1);
      chk("wake flag", 32'h1, 32'(flags[ch]));
      chk("wake pulse", 32'(w + 1), 32'(wakes));
      ev(ch, 1'b0);
      chk("no fall wake", 32'(w + 1), 32'(wakes));
      drain(ch, n);
      chk("nothing stored", 32'h0, 32'(n));
    end
    // Idle: stores only with timer running and stop-in-idle low; mode 111 captures in run
    for (k = 0; k < 4; k++) begin
      cpu_sleep <= 1'b0;
      cpu_idle <= (k < 3);
      timer3.running <= (k != 2);
      apb(1'b1, adr(ch, 1'b1), {18'h0, 1'(k == 1), 10'h0, (k == 3) ? `MODE_INT : `MODE_RISE});
      ev(ch, 1'b1);
      if (k == 0 || k == 3) begin
        fifo_q.push_back(timer3.count);
      end
      ev(ch, 1'b0);
      drain(ch, n);
      chk("idle capture", 32'(k == 0 || k == 3), 32'(n));
    end
    complete_run();
  end
endmodule // tb
`default_nettype wire
